/* bench/tpm_drive_model.sv */
// Inverter drive, tachometer and stop switch model
`timescale 1ns/1ps
`default_nettype none
module tpm_drive_model (
  input  wire logic       hclk,
  input  wire logic       tach_run,
  input  wire logic       stop_req,
  input  wire logic [5:0] gates,
  output logic            tach_in,
  output logic            estop_in,
  output logic            shoot
);
  int ph;
  initial begin
    tach_in = 1'b0;
    estop_in = 1'b0;
    shoot = 1'b0;
    ph = 0;
  end
  always @(posedge hclk) begin
    ph <= (ph == 39) ? 0 : ph + 1;
    if (tach_run && ph == 39) begin
      tach_in <= !tach_in;
    end
  end
  always @(posedge hclk) begin
    estop_in <= stop_req;
  end
  always @(posedge hclk) begin
    if ((gates[0] && gates[1]) || (gates[2] && gates[3]) || (gates[4] && gates[5])) begin
      shoot <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* bench/tpm_motor_pwm_checker.sv */
// Port-level assertions for the motor PWM block
`timescale 1ns/1ps
`default_nettype none
module tpm_motor_pwm_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        estop_in,
  input wire logic        pwm_u,
  input wire logic        pwm_u_n,
  input wire logic        pwm_v,
  input wire logic        pwm_v_n,
  input wire logic        pwm_w,
  input wire logic        pwm_w_n,
  input wire logic        irq
);
  import tpm_pkg::*;
  // ----------------------------------------------------------------------
  // Helper decode of accepted transfers
  // ----------------------------------------------------------------------
  logic rd_tk;
  logic rd_st;
  logic wr_mk;
  logic any_out;
  assign rd_tk = hsel && hready && htrans[1] && !hwrite;
  assign rd_st = rd_tk && (haddr[5:0] == OFS_STATUS);
  assign wr_mk = hsel && hready && htrans[1] && hwrite && (haddr[5:0] == OFS_MASK);
  assign any_out = pwm_u || pwm_u_n || pwm_v || pwm_v_n || pwm_w || pwm_w_n;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_no_overlap: assert property (!(pwm_u && pwm_u_n) && !(pwm_v && pwm_v_n) && !(pwm_w && pwm_w_n))
    else $error("complementary pair high together");
  a_gap_comp: assert property (($rose(pwm_u_n) |-> !$past(pwm_u)) and ($rose(pwm_v_n) |-> !$past(pwm_v)))
    else $error("no dead gap before complementary output");
  a_gap_true: assert property (($rose(pwm_u) |-> !$past(pwm_u_n)) and ($rose(pwm_w) |-> !$past(pwm_w_n)))
    else $error("no dead gap before true output");
  a_estop_cut: assert property (estop_in |-> !any_out)
    else $error("output active during emergency stop");
  a_estop_hold: assert property (estop_in |=> !any_out)
    else $error("output active right after emergency stop");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  a_unmapped_zero: assert property (rd_tk && haddr[5:0] > OFS_COUNT |=> hrdata == 32'h0)
    else $error("unmapped offset read not zero");
  a_ctrl_spare: assert property (rd_tk && haddr[5:0] == OFS_CTRL |=> hrdata[31:4] == 28'h0)
    else $error("control spare bits not zero");
  a_status_width: assert property (rd_st |=> hrdata[31:8] == 24'h0)
    else $error("status wider than eight flags");
  a_irq_drop: assert property ($fell(irq) |-> $past(rd_st, 1) || $past(wr_mk, 2) || $past(wr_mk, 3))
    else $error("interrupt dropped without status read or mask write");
endmodule
bind tpm_motor_pwm tpm_motor_pwm_checker u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .estop_in(estop_in),
  .pwm_u(pwm_u), .pwm_u_n(pwm_u_n), .pwm_v(pwm_v), .pwm_v_n(pwm_v_n), .pwm_w(pwm_w), .pwm_w_n(pwm_w_n),
  .irq(irq)
);
`default_nettype wire

/* bench/tpm_motor_pwm_test.sv */
// Testbench: registers, waveform timing, stop, interrupt and speed
`timescale 1ns/1ps
`default_nettype none
module tpm_motor_pwm_test;
  import tpm_pkg::*;
  logic             hclk, hresetn, hsel, hwrite, tach_run, stop_req;
  logic [31:0]      haddr, hwdata, rd;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  wire logic        hready, hreadyout, hresp, irq, tach_in, estop_in, shoot;
  wire logic        pwm_u, pwm_u_n, pwm_v, pwm_v_n, pwm_w, pwm_w_n;
  wire logic [31:0] hrdata;
  wire logic [5:0]  outs;
  int               errors, n_checks, hi, per;
  logic [5:0]       ofs [11] = '{OFS_CTRL, OFS_PRESC, OFS_PERIOD, OFS_CMP_U, OFS_CMP_V, OFS_CMP_W,
                                 OFS_DEAD, OFS_MASK, OFS_STATUS, 6'h30, OFS_REPEAT};
  logic [31:0]      rst_v [11] = '{0, 0, 32'h3ff, 0, 0, 0, 0, 0, 0, 0, 0};
  logic [31:0]      wr_v [11] = '{32'h0e, 32'hfe, 32'h3fe, 32'h3fe, 32'h3fe, 32'h3fe, 32'h3e, 32'hfe, 0, 0, 32'hfe};
  int               hi_exp [2][6] = '{'{17, 17, 5, 29, 29, 5}, '{33, 33, 9, 57, 57, 9}};
  int               per_exp [2] = '{40, 72};
  assign hready = hreadyout;
  assign outs = {pwm_w_n, pwm_w, pwm_v_n, pwm_v, pwm_u_n, pwm_u};
  tpm_motor_pwm uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .tach_in(tach_in), .estop_in(estop_in), .pwm_u(pwm_u), .pwm_u_n(pwm_u_n),
    .pwm_v(pwm_v), .pwm_v_n(pwm_v_n), .pwm_w(pwm_w), .pwm_w_n(pwm_w_n), .irq(irq)
  );
  tpm_drive_model u_drv (
    .hclk(hclk), .tach_run(tach_run), .stop_req(stop_req), .gates(outs),
    .tach_in(tach_in), .estop_in(estop_in), .shoot(shoot)
  );
  // ----------------------------------------------------------------------
  // Clock, verdict, compare and bus tasks
  // ----------------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic print_verdict();
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // One single transfer; called right after a rising edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {26'h0, a};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdr(input logic [5:0] a);
    bus(1'b0, a, 32'h0, rd);
  endtask
  // High time and rise-to-rise period of one output, in cycles
  task automatic measure(input int idx, output int h, output int p);
    h = 0;
    p = 0;
    while (outs[idx] !== 1'b0) @(posedge hclk);
    while (outs[idx] !== 1'b1) @(posedge hclk);
    while (outs[idx] === 1'b1) begin
      h++;
      p++;
      @(posedge hclk);
    end
    while (outs[idx] !== 1'b1) begin
      p++;
      @(posedge hclk);
    end
  endtask
  // Watchdog
  initial begin
    #400000;
    errors++;
    print_verdict();
  end
  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tach_run = 1'b0;
    stop_req = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 11; i++) begin
      rdr(ofs[i]);
      check(rd, rst_v[i], "reset value");
      wr(ofs[i], 32'hfffffffe);
      rdr(ofs[i]);
      check(rd, wr_v[i], "field width");
    end
    wr(OFS_PRESC, 32'h3);
    wr(OFS_PERIOD, 32'h9);
    wr(OFS_CMP_U, 32'h5);
    wr(OFS_CMP_V, 32'h2);
    wr(OFS_CMP_W, 32'h8);
    wr(OFS_DEAD, 32'h2);
    wr(OFS_MASK, 32'h80);
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CTRL, (m == 1) ? 32'h7 : 32'h5);
      repeat (100) @(posedge hclk);
      for (int i = 0; i < 6; i++) begin
        measure(i, hi, per);
        check(hi, hi_exp[m][i], "pulse width");
        check(per, per_exp[m], "pwm period");
      end
    end
    tach_run <= 1'b1;
    for (int e = 0; e < 4; e++) begin
      wr(OFS_CTRL, 32'h1 | (e << CTRL_EDGE_L));
      repeat (300) @(posedge hclk);
      rdr(OFS_STATUS);
      repeat (200) @(posedge hclk);
      rdr(OFS_STATUS);
      check(rd[FL_TACH], e != 0, "tach flag");
      rdr(OFS_SPEED);
      if (e != 0) check(rd, (e == 3) ? 10 : 20, "speed");
    end
    check(irq, 1'b0, "masked flags raise irq");
    stop_req <= 1'b1;
    repeat (3) @(posedge hclk);
    check(outs, 6'h0, "outputs during stop");
    check(irq, 1'b1, "stop interrupt");
    stop_req <= 1'b0;
    repeat (50) @(posedge hclk);
    check(outs, 6'h0, "outputs after stop release");
    rdr(OFS_COUNT);
    check(rd[CNT_STOP], 1'b1, "stop latch");
    check(rd[CNT_W-1:0], 0, "counter held in stop");
    rdr(OFS_STATUS);
    check(rd[FL_ESTOP], 1'b1, "stop flag");
    repeat (3) @(posedge hclk);
    check(irq, 1'b0, "irq after status read");
    wr(OFS_CTRL, 32'h105);
    measure(0, hi, per);
    check(per, 40, "period after re-arm");
    wr(OFS_MASK, 32'h0);
    stop_req <= 1'b1;
    repeat (3) @(posedge hclk);
    stop_req <= 1'b0;
    repeat (3) @(posedge hclk);
    check(irq, 1'b0, "masked stop interrupt");
    check(shoot, 1'b0, "shoot-through seen");
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdr(OFS_PERIOD);
    check(rd, 32'h3ff, "period after second reset");
    print_verdict();
  end
endmodule
`default_nettype wire

/* common/tpm_pkg.sv */
// Package: register map, field positions and reset values of the motor PWM block
package tpm_pkg;
  // -------------------------------------------------------------------------
  // Widths
  // -------------------------------------------------------------------------
  localparam int CNT_W   = 10;
  localparam int PRE_W   = 8;
  localparam int DT_W    = 6;
  localparam int SPD_W   = 16;
  localparam int REP_W   = 8;
  localparam int FLAG_W  = 8;
  localparam int ADDR_W  = 6;

  // -------------------------------------------------------------------------
  // Register byte offsets
  // -------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_PRESC  = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_CMP_U  = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_CMP_V  = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_CMP_W  = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_DEAD   = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_REPEAT = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_SPEED  = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 6'h2c;

  // -------------------------------------------------------------------------
  // Control and count register fields
  // -------------------------------------------------------------------------
  localparam int CTRL_EN     = 0;
  localparam int CTRL_MODE   = 1;
  localparam int CTRL_EDGE_L = 2;
  localparam int CTRL_EDGE_H = 3;
  localparam int CTRL_REARM  = 8;
  localparam int CNT_STOP    = 16;
  localparam int CNT_DIR     = 17;

  // -------------------------------------------------------------------------
  // Status flag positions
  // -------------------------------------------------------------------------
  localparam int FL_PERIOD = 0;
  localparam int FL_TOP    = 1;
  localparam int FL_CMP_U  = 2;
  localparam int FL_CMP_V  = 3;
  localparam int FL_CMP_W  = 4;
  localparam int FL_TACH   = 5;
  localparam int FL_TOVF   = 6;
  localparam int FL_ESTOP  = 7;

  // -------------------------------------------------------------------------
  // Reset values and encodings
  // -------------------------------------------------------------------------
  localparam logic [CNT_W-1:0] PERIOD_RST = 10'h3ff;
  localparam logic [DT_W-1:0]  DEAD_RST   = 6'h00;
  localparam logic [1:0]       EDGE_NONE  = 2'h0;
  localparam logic [1:0]       EDGE_RISE  = 2'h1;
  localparam logic [1:0]       EDGE_FALL  = 2'h2;
  localparam logic [1:0]       EDGE_BOTH  = 2'h3;
  localparam logic [1:0]       HTRANS_NONSEQ = 2'h2;

  typedef enum logic {TPM_CLASSIC, TPM_CENTER} tpm_mode_t;
endpackage

/* hw/tpm_deadband.sv */
// Dead-time inserter for one phase: true and complementary outputs
`timescale 1ns/1ps
`default_nettype none
module tpm_deadband (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   run,
  input  wire logic                   ref_in,
  input  wire logic [tpm_pkg::DT_W-1:0] dead,
  output logic                        out_hi,
  output logic                        out_lo
);
  import tpm_pkg::*;

  logic            ref_r;
  logic [DT_W-1:0] cnt_r;

  // --------------------------------------------------------------------------
  // Edge gap then drive the new side
  // --------------------------------------------------------------------------
  // R06: dead time gap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_r  <= 1'b0;
      cnt_r  <= '0;
      out_hi <= 1'b0;
      out_lo <= 1'b0;
    end else if (!run) begin
      ref_r  <= ref_in;
      cnt_r  <= dead;
      out_hi <= 1'b0;
      out_lo <= 1'b0;
    end else if (ref_in != ref_r) begin
      ref_r  <= ref_in;
      cnt_r  <= dead;
      out_hi <= 1'b0;
      out_lo <= 1'b0;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end else begin
      // R03: complementary pair
      out_hi <= ref_r;
      out_lo <= ~ref_r;
    end
  end
endmodule
`default_nettype wire

/* hw/tpm_motor_pwm.sv */
// Three-phase motor PWM controller with AHB-Lite register slave
// Functional notes
// R01: Six PWM output pins drive the external three-phase inverter.
// R02: One PWM per phase U, V, W from a shared 10-bit counter.
// R03: Each phase also has a complementary output.
// R04: Classic or zero-centered generation mode is selectable.
// R05: Counter clock is hclk divided by an 8-bit prescaler.
// R06: Programmable 6-bit dead time separates each complementary pair.
// R07: Rotor speed is measured from tachometer edges, 16-bit result.
// R08: Software selects rising, falling or both tachometer edges.
// R09: Emergency stop input stops the outputs at once without firmware.
// R10: One interrupt output with eight cause flags.
// R11: Classic counts up and wraps; centered counts up then down.
// R12: Emergency stop holds outputs inactive until software re-arms.
//
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module tpm_motor_pwm (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        tach_in,
  input  wire logic        estop_in,
  output logic             pwm_u,
  output logic             pwm_u_n,
  output logic             pwm_v,
  output logic             pwm_v_n,
  output logic             pwm_w,
  output logic             pwm_w_n,
  output logic             irq
);
  import tpm_pkg::*;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic              en_r;
  tpm_mode_t         mode_r;
  logic [1:0]        edge_r;
  logic [PRE_W-1:0]  presc_r;
  logic [CNT_W-1:0]  period_r;
  logic [CNT_W-1:0]  cmp_r [3];
  logic [DT_W-1:0]   dead_r;
  logic [REP_W-1:0]  rep_r;
  logic [FLAG_W-1:0] status_r;
  logic [FLAG_W-1:0] mask_r;
  logic              stop_r;

  // Bus data phase state
  logic              wr_pend_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic              acc;
  logic              rd_acc;
  logic              stat_rd;

  // Counter state
  logic [PRE_W-1:0]  pre_cnt_r;
  logic [CNT_W-1:0]  cnt_r;
  logic              down_r;
  logic [REP_W-1:0]  rep_cnt_r;
  logic              tick;
  logic              run;
  logic              at_top;
  logic              at_zero;
  logic              rep_hit;
  logic [2:0]        ref_ph;
  logic [2:0]        cmp_hit;
  logic [2:0]        hi_ph;
  logic [2:0]        lo_ph;
  logic [SPD_W-1:0]  speed;
  logic              cap_pulse;
  logic              ovf_pulse;
  logic [FLAG_W-1:0] ev;
  logic [31:0]       rd_mux;

  // --------------------------------------------------------------------------
  // AHB-Lite decode
  // --------------------------------------------------------------------------
  // Zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc       = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == 2'h3);
  assign rd_acc    = acc & ~hwrite;
  assign stat_rd   = rd_acc & (haddr[ADDR_W-1:0] == OFS_STATUS);

  // Latch address phase of a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      wr_pend_r <= acc & hwrite;
      wr_addr_r <= haddr[ADDR_W-1:0];
    end
  end

  // Write data phase into control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_r     <= 1'b0;
      mode_r   <= TPM_CLASSIC;
      edge_r   <= EDGE_NONE;
      presc_r  <= '0;
      period_r <= PERIOD_RST;
      cmp_r[0] <= '0;
      cmp_r[1] <= '0;
      cmp_r[2] <= '0;
      dead_r   <= DEAD_RST;
      rep_r    <= '0;
      mask_r   <= '0;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        OFS_CTRL: begin
          en_r   <= hwdata[CTRL_EN];
          // R04: mode select
          mode_r <= tpm_mode_t'(hwdata[CTRL_MODE]);
          edge_r <= hwdata[CTRL_EDGE_H:CTRL_EDGE_L];
        end
        OFS_PRESC:  presc_r  <= hwdata[PRE_W-1:0];
        OFS_PERIOD: period_r <= hwdata[CNT_W-1:0];
        OFS_CMP_U:  cmp_r[0] <= hwdata[CNT_W-1:0];
        OFS_CMP_V:  cmp_r[1] <= hwdata[CNT_W-1:0];
        OFS_CMP_W:  cmp_r[2] <= hwdata[CNT_W-1:0];
        OFS_DEAD:   dead_r   <= hwdata[DT_W-1:0];
        OFS_REPEAT: rep_r    <= hwdata[REP_W-1:0];
        OFS_MASK:   mask_r   <= hwdata[FLAG_W-1:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Emergency stop latch
  // --------------------------------------------------------------------------
  // R12: hold until re-arm
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_r <= 1'b0;
    end else if (estop_in) begin
      stop_r <= 1'b1;
    end else if (wr_pend_r && wr_addr_r == OFS_CTRL && hwdata[CTRL_REARM]) begin
      stop_r <= 1'b0;
    end
  end

  assign run = en_r & ~stop_r & ~estop_in;

  // --------------------------------------------------------------------------
  // Prescaler
  // --------------------------------------------------------------------------
  // R05: divide hclk by presc+1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_r <= '0;
    end else if (!run || pre_cnt_r >= presc_r) begin
      pre_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 1'b1;
    end
  end

  assign tick    = run & (pre_cnt_r >= presc_r);
  assign at_top  = (cnt_r >= period_r);
  assign at_zero = (cnt_r == '0);

  // --------------------------------------------------------------------------
  // PWM counter
  // --------------------------------------------------------------------------
  // R11: up-wrap or up-down
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r  <= '0;
      down_r <= 1'b0;
    end else if (!run) begin
      cnt_r  <= '0;
      down_r <= 1'b0;
    end else if (tick) begin
      if (mode_r == TPM_CLASSIC) begin
        down_r <= 1'b0;
        cnt_r  <= at_top ? '0 : cnt_r + 1'b1;
      end else if (down_r) begin
        if (cnt_r <= 10'h001) down_r <= 1'b0;
        cnt_r <= at_zero ? cnt_r : cnt_r - 1'b1;
      end else begin
        if (at_top) begin
          down_r <= 1'b1;
          cnt_r  <= (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

  // Repetition counter: period flag every rep+1 periods
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rep_cnt_r <= '0;
    end else if (!run) begin
      rep_cnt_r <= '0;
    end else if (tick && at_zero) begin
      rep_cnt_r <= (rep_cnt_r >= rep_r) ? '0 : rep_cnt_r + 1'b1;
    end
  end

  assign rep_hit = tick & at_zero & (rep_cnt_r >= rep_r);

  // --------------------------------------------------------------------------
  // Phases: compare, dead time, pins
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ph
      // R02: compare per phase
      assign ref_ph[g]  = run & (cnt_r < cmp_r[g]);
      assign cmp_hit[g] = tick & (cnt_r == cmp_r[g]);
      tpm_deadband u_db (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (run),
        .ref_in  (ref_ph[g]),
        .dead    (dead_r),
        .out_hi  (hi_ph[g]),
        .out_lo  (lo_ph[g])
      );
    end
  endgenerate

  // R09: direct gate by stop input
  // R01: six output pins
  assign pwm_u   = hi_ph[0] & ~estop_in & ~stop_r;
  assign pwm_u_n = lo_ph[0] & ~estop_in & ~stop_r;
  assign pwm_v   = hi_ph[1] & ~estop_in & ~stop_r;
  assign pwm_v_n = lo_ph[1] & ~estop_in & ~stop_r;
  assign pwm_w   = hi_ph[2] & ~estop_in & ~stop_r;
  assign pwm_w_n = lo_ph[2] & ~estop_in & ~stop_r;

  // --------------------------------------------------------------------------
  // Tachometer
  // --------------------------------------------------------------------------
  tpm_tach u_tach (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .tick      (tick),
    .tach_in   (tach_in),
    .edge_sel  (edge_r),
    .speed     (speed),
    .cap_pulse (cap_pulse),
    .ovf_pulse (ovf_pulse)
  );

  // --------------------------------------------------------------------------
  // Interrupt flags
  // --------------------------------------------------------------------------
  always_comb begin
    ev            = '0;
    ev[FL_PERIOD] = rep_hit;
    ev[FL_TOP]    = tick & at_top;
    ev[FL_CMP_U]  = cmp_hit[0];
    ev[FL_CMP_V]  = cmp_hit[1];
    ev[FL_CMP_W]  = cmp_hit[2];
    ev[FL_TACH]   = cap_pulse;
    ev[FL_TOVF]   = ovf_pulse;
    ev[FL_ESTOP]  = estop_in & ~stop_r;
  end

  // R10: sticky flags, read clears, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) status_r <= '0;
    else          status_r <= (stat_rd ? '0 : status_r) | ev;
  end

  // R10: single masked interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq <= 1'b0;
    else          irq <= |(((stat_rd ? '0 : status_r) | ev) & mask_r);
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    case (haddr[ADDR_W-1:0])
      OFS_CTRL: begin
        rd_mux[CTRL_EN]                 = en_r;
        rd_mux[CTRL_MODE]               = mode_r;
        rd_mux[CTRL_EDGE_H:CTRL_EDGE_L] = edge_r;
      end
      OFS_PRESC:  rd_mux[PRE_W-1:0]  = presc_r;
      OFS_PERIOD: rd_mux[CNT_W-1:0]  = period_r;
      OFS_CMP_U:  rd_mux[CNT_W-1:0]  = cmp_r[0];
      OFS_CMP_V:  rd_mux[CNT_W-1:0]  = cmp_r[1];
      OFS_CMP_W:  rd_mux[CNT_W-1:0]  = cmp_r[2];
      OFS_DEAD:   rd_mux[DT_W-1:0]   = dead_r;
      OFS_REPEAT: rd_mux[REP_W-1:0]  = rep_r;
      OFS_SPEED:  rd_mux[SPD_W-1:0]  = speed;
      OFS_STATUS: rd_mux[FLAG_W-1:0] = status_r | ev;
      OFS_MASK:   rd_mux[FLAG_W-1:0] = mask_r;
      OFS_COUNT: begin
        rd_mux[CNT_W-1:0] = cnt_r;
        rd_mux[CNT_STOP]  = stop_r;
        rd_mux[CNT_DIR]   = down_r;
      end
      default: rd_mux = '0;
    endcase
  end

  // Read data captured at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)    hrdata <= '0;
    else if (rd_acc) hrdata <= rd_mux;
  end

  // Size is not checked: only whole words are used
  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[31:ADDR_W]};
endmodule
`default_nettype wire

/* hw/tpm_tach.sv */
// Tachometer edge detector and period measurement
`timescale 1ns/1ps
`default_nettype none
module tpm_tach (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    tick,
  input  wire logic                    tach_in,
  input  wire logic [1:0]              edge_sel,
  output logic [tpm_pkg::SPD_W-1:0]    speed,
  output logic                         cap_pulse,
  output logic                         ovf_pulse
);
  import tpm_pkg::*;

  logic             tach_d_r;
  logic [SPD_W-1:0] cnt_r;
  logic             hit;

  // --------------------------------------------------------------------------
  // Edge selection
  // --------------------------------------------------------------------------
  // R08: programmable edges
  always_comb begin
    case (edge_sel)
      EDGE_RISE: hit = tach_in & ~tach_d_r;
      EDGE_FALL: hit = ~tach_in & tach_d_r;
      EDGE_BOTH: hit = tach_in ^ tach_d_r;
      default:   hit = 1'b0;
    endcase
  end

  // Input history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tach_d_r <= 1'b0;
    else          tach_d_r <= tach_in;
  end

  // --------------------------------------------------------------------------
  // Period counter and capture
  // --------------------------------------------------------------------------
  // R07: speed capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r     <= '0;
      speed     <= '0;
      cap_pulse <= 1'b0;
      ovf_pulse <= 1'b0;
    end else begin
      cap_pulse <= hit;
      ovf_pulse <= 1'b0;
      if (hit) begin
        speed <= cnt_r;
        // A tick on the capture edge opens the new count, so none is lost
        cnt_r <= {{(SPD_W-1){1'b0}}, tick};
      end else if (tick) begin
        if (cnt_r == {SPD_W{1'b1}}) ovf_pulse <= 1'b1; // Saturated, no edge seen
        else                        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire
